// >>> src/sar_adc_mux_sequencer.sv
// control logic for a 16-channel 8-bit successive-approximation converter
`timescale 1ns/100ps
module sar_adc_mux_sequencer
   import sar_seq_pkg::*;
#(
   parameter int unsigned NCHAN = CHAN_COUNT,
   parameter int unsigned NBITS = RESULT_BITS
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 conv_clk_tick,
   input  wire logic                 conversion_start_strobe,
   input  wire logic                 channel_latch_strobe,
   input  wire logic [CHAN_BITS-1:0] chan_addr,
   input  wire logic                 expansion_enable,
   input  wire logic                 output_enable,
   input  wire logic                 comparator_high,
   output logic      [NCHAN-1:0]     chan_switch_on,
   output logic      [NBITS-1:0]     trial_code,
   output logic                      end_of_conversion,
   output logic      [NBITS-1:0]     data_out,
   output logic      [NBITS-1:0]     data_oe
);

   // ***************************************************
   // registers
   // ***************************************************
   localparam int unsigned     BIT_W = $clog2(NBITS);
   seq_state_type              state_q, state_d;
   logic [CHAN_BITS-1:0]       chan_q, chan_d;
   logic [NBITS-1:0]           approx_q, approx_d;
   logic [NBITS-1:0]           result_q, result_d;
   logic [BIT_W-1:0]           bit_q, bit_d;
   logic                       eoc_q, eoc_d;
   logic                       sc_q, ale_q;
   logic                       sc_rise, sc_fall, ale_rise;

   // edge detectors on strobes
   assign sc_rise  = conversion_start_strobe & ~sc_q;
   assign sc_fall  = ~conversion_start_strobe & sc_q;
   assign ale_rise = channel_latch_strobe & ~ale_q;

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      state_d  = state_q;
      chan_d   = chan_q;
      approx_d = approx_q;
      result_d = result_q;
      bit_d    = bit_q;
      eoc_d    = eoc_q;
      if (ale_rise) begin
         chan_d = chan_addr;
      end
      if (sc_rise) begin
         approx_d = RESULT_RESET;
         state_d  = ST_ARMED;
      end else if (sc_fall && state_q == ST_ARMED) begin
         state_d  = ST_CONVERT;
         bit_d    = BIT_W'(NBITS - 1);
         approx_d = RESULT_RESET;
         approx_d[NBITS-1] = 1'b1;
      end else if (conv_clk_tick) begin
         case (state_q)
            ST_ARMED: begin
               eoc_d = 1'b0;
            end
            ST_CONVERT: begin
               eoc_d = 1'b0;
               // keep trial bit only if input at or above trial level
               approx_d[bit_q] = comparator_high;
               if (bit_q == '0) begin
                  state_d = ST_FINISH;
               end else begin
                  bit_d = bit_q - 1'b1;
                  approx_d[bit_q - 1'b1] = 1'b1;
               end
            end
            ST_FINISH: begin
               result_d = approx_q;
               eoc_d    = 1'b1;
               state_d  = ST_IDLE;
            end
            ST_IDLE: begin
               eoc_d = eoc_q;
            end
            default: begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   // registers only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q  <= ST_IDLE;
         chan_q   <= CHAN_RESET;
         approx_q <= RESULT_RESET;
         result_q <= RESULT_RESET;
         bit_q    <= '0;
         eoc_q    <= 1'b1;
         sc_q     <= 1'b0;
         ale_q    <= 1'b0;
      end else begin
         state_q  <= state_d;
         chan_q   <= chan_d;
         approx_q <= approx_d;
         result_q <= result_d;
         bit_q    <= bit_d;
         eoc_q    <= eoc_d;
         sc_q     <= conversion_start_strobe;
         ale_q    <= channel_latch_strobe;
      end
   end

   // ***************************************************
   // channel decode and outputs
   // ***************************************************
   genvar gi;
   generate
      for (gi = 0; gi < NCHAN; gi++) begin : g_chan
         // one-hot switch, all off without expansion
         assign chan_switch_on[gi] = expansion_enable && (chan_q == CHAN_BITS'(gi));
      end
   endgenerate

   assign trial_code        = approx_q;
   assign end_of_conversion = eoc_q;
   assign data_out          = result_q;
   assign data_oe           = {NBITS{output_enable}};

   // ***************************************************
   // assertions
   // ***************************************************
   int unsigned ticks_since_sc;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ticks_since_sc <= 0;
      end else if (sc_rise) begin
         ticks_since_sc <= 0;
      end else if (conv_clk_tick && ticks_since_sc < 100) begin
         ticks_since_sc <= ticks_since_sc + 1;
      end
   end

   sequence s_start_rise;
      conversion_start_strobe && !sc_q;
   endsequence

   sequence s_last_trial;
      state_q == ST_CONVERT && bit_q == '0 && conv_clk_tick && !sc_rise;
   endsequence

   // start strobe handling
   a_sar_clear: assert property (@(posedge clk) disable iff (rst)
      s_start_rise |=> approx_q == RESULT_RESET)
      else $error("register not cleared on start rise");
   a_eoc_falls: assert property (@(posedge clk) disable iff (rst)
      (end_of_conversion && ticks_since_sc >= EOC_DELAY_MAX && state_q != ST_IDLE
       && !sc_rise) |-> 1'b0)
      else $error("done not low within eight clocks");
   // channel latch, mux decode, conversion start and abandon
   a_chan_latch: assert property (@(posedge clk) disable iff (rst)
      (channel_latch_strobe && !ale_q) |=> chan_q == $past(chan_addr))
      else $error("channel code not captured");
   a_mux_off: assert property (@(posedge clk) disable iff (rst)
      !expansion_enable |-> chan_switch_on == '0)
      else $error("channel on without expansion");
   a_mux_onehot: assert property (@(posedge clk) disable iff (rst)
      expansion_enable |-> $onehot(chan_switch_on))
      else $error("mux not one-hot");
   a_conv_start: assert property (@(posedge clk) disable iff (rst)
      (sc_fall && state_q == ST_ARMED) |=> state_q == ST_CONVERT
       && approx_q[NBITS-1])
      else $error("conversion did not start");
   a_abandon: assert property (@(posedge clk) disable iff (rst)
      (s_start_rise and state_q == ST_CONVERT) |=> state_q == ST_ARMED)
      else $error("running conversion not abandoned");
   // result latching and bit trials
   a_result_hold: assert property (@(posedge clk) disable iff (rst)
      (state_q != ST_FINISH) |=> $stable(data_out))
      else $error("result changed outside finish");
   a_eoc_rise: assert property (@(posedge clk) disable iff (rst)
      (state_q == ST_FINISH && conv_clk_tick && !sc_rise && !sc_fall)
       |=> end_of_conversion && data_out == $past(approx_q))
      else $error("done not raised with result");
   a_trial_keep: assert property (@(posedge clk) disable iff (rst)
      (state_q == ST_CONVERT && conv_clk_tick && !sc_rise && !sc_fall)
       |=> approx_q[$past(bit_q)] == $past(comparator_high))
      else $error("trial bit wrong");
   // output drivers
   a_data_oe: assert property (@(posedge clk) disable iff (rst)
      data_oe == {NBITS{output_enable}})
      else $error("output enable mismatch");

   // done only falls on a conversion clock, never straight off the strobe
   a_eoc_early: assert property (@(posedge clk) disable iff (rst)
      $fell(end_of_conversion) |-> $past(conv_clk_tick))
      else $error("done fell without a conversion clock");

   // idle always shows done high
   a_idle_done: assert property (@(posedge clk) disable iff (rst)
      state_q == ST_IDLE |-> end_of_conversion)
      else $error("idle without done");

   // the bit under trial is always set while converting
   a_trial_set: assert property (@(posedge clk) disable iff (rst)
      state_q == ST_CONVERT |-> approx_q[bit_q])
      else $error("trial bit not set");

   // code register only moves on a latch strobe rise
   a_chan_keep: assert property (@(posedge clk) disable iff (rst)
      !(channel_latch_strobe && !ale_q) |=> $stable(chan_q))
      else $error("channel code moved without strobe");

   // eighth trial hands over to the finishing step
   a_last_trial: assert property (@(posedge clk) disable iff (rst)
      s_last_trial |=> state_q == ST_FINISH)
      else $error("no finish after last trial");

endmodule

// >>> src/sar_seq_pkg.sv
// constants and types for the converter control logic
// ***************************************************
// Summary of operation
// ***************************************************
// Summary of operation
// - while expansion is high, exactly one of sixteen analog inputs is switched to the converter by latched code
// - channel code is captured on the rising edge of the latch strobe
// - selected channel reaches the mux output only while expansion is high
// - rising edge of the start strobe clears the approximation register
// - falling edge of the start strobe begins a new conversion
// - a new start strobe abandons any running conversion
// - done output falls one to eight conversion clocks after start rises
// - each result comes from eight approximation steps, one bit each
// - result is straight binary; data outputs float unless output enable is high
// - code selects channel of same number; expansion low turns all channels off
// - output latches hold the last result until a newer conversion replaces it
package sar_seq_pkg;
   localparam int unsigned CHAN_BITS    = 4;
   localparam int unsigned CHAN_COUNT   = 16;
   localparam int unsigned RESULT_BITS  = 8;
   localparam logic [7:0]  RESULT_RESET = 8'h00;
   localparam logic [3:0]  CHAN_RESET   = 4'h0;
   localparam int unsigned EOC_DELAY_MIN = 1;   // conversion clocks
   localparam int unsigned EOC_DELAY_MAX = 8;   // conversion clocks

   // gray coded along idle -> armed -> converting -> finishing
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ARMED   = 2'b01,
      ST_CONVERT = 2'b11,
      ST_FINISH  = 2'b10
   } seq_state_type;
endpackage

// >>> sim/analog_source.sv
// comparator model standing in for the ladder and the selected analog input
`timescale 1ns/100ps
module analog_source (
   input  wire logic [7:0] trial_code,
   input  wire logic [7:0] level,
   output logic            comparator_high
);
   // high while the input sits at or above the trial level
   assign comparator_high = (level >= trial_code);
endmodule

// >>> sim/sar_adc_mux_sequencer_tb.sv
// self-checking bench for the converter control logic
`timescale 1ns/100ps
module sar_adc_mux_sequencer_tb;
   import sar_seq_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        tick = 1'b0;
   logic        tick_run = 1'b0;
   logic        start = 1'b0;
   logic        free_run = 1'b0;
   logic        start_pin;
   logic        latch = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic        exp_en = 1'b0;
   logic        oe = 1'b0;
   logic        cmp;
   logic [7:0]  level = 8'h00;
   logic [15:0] sw;
   logic [7:0]  trial;
   logic        eoc;
   logic [7:0]  dout;
   logic [7:0]  doe;
   int          mismatches = 0;
   int          n_checks = 0;
   int          cycles = 0;
   sar_adc_mux_sequencer u_dut (.clk(clk), .rst(rst), .conv_clk_tick(tick),
      .conversion_start_strobe(start_pin), .channel_latch_strobe(latch), .chan_addr(addr),
      .expansion_enable(exp_en), .output_enable(oe), .comparator_high(cmp),
      .chan_switch_on(sw), .trial_code(trial), .end_of_conversion(eoc),
      .data_out(dout), .data_oe(doe));
   analog_source u_src (.trial_code(trial), .level(level), .comparator_high(cmp));
   // free-running mode feeds done back into the start input
   assign start_pin = free_run ? eoc : start;
   // clock, conversion clock pulse every fourth cycle, run limit
   always #2.5 clk = ~clk;
   always @(negedge clk) begin
      tick <= tick_run && (cycles % 4 == 3);
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task final_report;
      if (mismatches == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task wait_eoc(input logic val, input int lim);
      int n;
      n = 0;
      while (eoc !== val && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk({15'h0000, eoc}, {15'h0000, val});
   endtask
   // latch every code, then turn expansion off
   task channels;
      exp_en = 1'b1;
      for (int k = 0; k < 16; k++) begin
         @(negedge clk) addr = 4'(k);
         latch = 1'b1;
         @(negedge clk) latch = 1'b0;
         @(negedge clk) addr = ~4'(k);
         chk(sw, 16'h0001 << k);
      end
      exp_en = 1'b0;
      @(negedge clk) chk(sw, 16'h0000);
   endtask
   // one start strobe; full waits for the result, else returns mid-run
   task convert(input logic [7:0] v, input bit full);
      level = v;
      tick_run = 1'b0;
      @(negedge clk) start = 1'b1;
      @(negedge clk) start = 1'b0;
      chk({8'h00, trial}, 16'h0000);
      @(negedge clk) chk({8'h00, trial}, 16'h0080);
      tick_run = 1'b1;
      wait_eoc(1'b0, 32);
      if (full) begin
         wait_eoc(1'b1, 45);
         chk({8'h00, dout}, {8'h00, v});
      end else repeat (14) @(negedge clk);
   endtask
   // result held while the input moves; enable only steers the drivers
   task hold_and_enable;
      level = 8'h11;
      oe = 1'b1;
      repeat (20) @(negedge clk);
      chk({8'h00, doe}, 16'h00FF);
      chk({8'h00, dout}, 16'h005A);
      oe = 1'b0;
      @(negedge clk) chk({8'h00, doe}, 16'h0000);
   endtask
   // done tied to start; switching over while done is high is the one host start
   task free_running;
      level = 8'hC3;
      free_run = 1'b1;
      wait_eoc(1'b0, 32);
      wait_eoc(1'b1, 45);
      level = 8'h3C;
      chk({8'h00, dout}, 16'h00C3);
      wait_eoc(1'b0, 32);
      wait_eoc(1'b1, 45);
      free_run = 1'b0;
      chk({8'h00, dout}, 16'h003C);
   endtask
   initial begin
      repeat (12) @(negedge clk);
      chk({7'h00, eoc, dout}, 16'h0100);
      rst = 1'b0;
      channels();
      convert(8'hA5, 1'b1);
      convert(8'h00, 1'b1);
      convert(8'hFF, 1'b1);
      convert(8'h3C, 1'b0);
      chk({15'h0000, eoc}, 16'h0000);
      convert(8'h5A, 1'b1);
      hold_and_enable();
      free_running();
      final_report();
   end
endmodule
